// [hw/tpw_top.v]
// pwm timer channel with apb register slave
// Notes on behaviour
// - pwm operation only when both operation mode bits are one
// - count source: undivided, /8, /32, or sub-clock /32 by bits 7:6
// - counter counts down per tick, as 8-bit or 16-bit modulator
// - at each pulse rising edge counter reloads and keeps counting
// - triggers are ignored once counting runs
// - 16-bit: high n ticks, period fixed at 65535 ticks
// - 8-bit: high n*(m+1) ticks, n upper byte, m lower byte
// - 8-bit: period 255*(m+1) ticks
// - triggered start by trigger pin edge or other timer overflow
// - software sets start flag to one to start counting
// - start flag zero stops the channel
// - interrupt request on each pulse falling edge
// - trigger pin is general input or trigger input
// - output pin carries pulse when its function select is on
// - timer value reads are undefined
// - write while stopped loads reload and counter together
// - write while running loads reload only, counter at next reload
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defines.vh"

module tpw_top (
    input  wire        REF_CLK,
    input  wire        RST_N,
    // apb register slave
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [7:0]  PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    // channel pins and other timer overflow
    input  wire        TRIG_IN_PIN,
    input  wire        SUB_CLK_PIN,
    input  wire        OTHER_OVF,
    // pulse pin and interrupt request
    output reg         PULSE_OUT_PIN,
    output reg         IRQ
);

    // ****************************************
    // declarations
    // ****************************************
    // registers, counters and pulse state
    reg  [7:0]  mode_q;
    reg  [7:0]  ctrl_q;
    reg  [15:0] reload_q;
    reg  [15:0] cnt_q;
    reg  [15:0] per_q;
    reg  [7:0]  pre_q;
    reg  [1:0]  ev_q;
    reg  [1:0]  mask_q;
    reg         run_q;
    reg         out_q;
    reg         out_prev_q;
    reg         reload_ev_q;

    // trigger sampler and filtered level
    reg         t1_q;
    reg         t2_q;
    reg         t3_q;
    reg         trig_lvl_q;
    wire        trig_lvl_d;
    wire        trig_edge;
    wire        trig_event;

    // start, stop and modulator terms
    wire        tick;
    wire        pwm_mode;
    wire        eight;
    wire        go;
    wire        stop;
    wire        unit;
    wire        pstart;
    wire [15:0] width_n;
    wire [15:0] period_n;
    wire [7:0]  presc_m;

    // bus decode, events and read path
    wire        first_acc;
    wire        wr_acc;
    wire        rd_acc;
    wire        fall_ev;
    wire [1:0]  ev_set;
    reg  [31:0] rd_data;
    reg         rd_err;

    // ****************************************
    // helpers
    // ****************************************
    // address match for one register
    // whole byte compare: unaligned addresses take the error path
    function hit;
        input [7:0] addr;
        input [7:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // decrement that holds at zero
    // holding keeps a spent width from wrapping into a long pulse
    function [15:0] dec16;
        input [15:0] v;
        begin
            dec16 = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
        end
    endfunction

    // ****************************************
    // count source
    // ****************************************
    // one-clock tick strobe; the undivided source strobes every clock
    tpw_tick_gen u_tick (
        .clk         (REF_CLK),
        .rst_n       (RST_N),
        .sub_clk_pin (SUB_CLK_PIN),
        .src_sel     (mode_q[`TPW_F_SRC]),
        .tick        (tick)
    );

    // ****************************************
    // apb access decode
    // ****************************************
    // one wait state: pready rises in the second access cycle
    // the registered pready costs that wait but keeps bus outputs on flops
    assign first_acc = PSEL & PENABLE & ~PREADY;
    assign wr_acc    = PSEL & PENABLE & PREADY & PWRITE;
    assign rd_acc    = first_acc & ~PWRITE;

    // read mux and unmapped detect
    always @* begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (PADDR)
            `TPW_OFF_MODE:   rd_data = {24'h000000, mode_q};
            // the running count is not exposed
            `TPW_OFF_TIMER:  rd_data = 32'h0000_0000;
            `TPW_OFF_CTRL:   rd_data = {24'h000000, ctrl_q};
            `TPW_OFF_STATUS: begin
                // events, then live run, pulse and trigger levels
                rd_data[1:0]            = ev_q;
                rd_data[`TPW_B_ST_RUN]  = run_q;
                rd_data[`TPW_B_ST_OUT]  = out_q;
                rd_data[`TPW_B_ST_TRIG] = trig_lvl_q;
            end
            `TPW_OFF_MASK:   rd_data = {30'h00000000, mask_q};
            // any other byte address is refused
            default:         rd_err  = 1'b1;
        endcase
    end

    // bus answer flops
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= first_acc;
            // read data is caught one edge early so it stands beside pready
            if (first_acc) begin
                // pslverr rises only with pready and falls with it
                PSLVERR <= rd_err;
                if (rd_acc)
                    PRDATA <= rd_data;
            end else begin
                PSLVERR <= 1'b0;
            end
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    // mode, control and mask writes
    // unmapped writes change nothing and answer with pslverr
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_q <= `TPW_RST_MODE;
            ctrl_q <= `TPW_RST_CTRL;
            mask_q <= `TPW_RST_EV;
        end else if (wr_acc) begin
            if (hit(PADDR, `TPW_OFF_MODE)) begin
                mode_q <= PWDATA[7:0];
                // the width bit is frozen while running: switching mid period
                // would mix the 8-bit and 16-bit period arithmetic
                if (run_q)
                    mode_q[`TPW_B_WIDTH8] <= mode_q[`TPW_B_WIDTH8];
            end
            if (hit(PADDR, `TPW_OFF_CTRL))
                ctrl_q <= PWDATA[7:0];
            if (hit(PADDR, `TPW_OFF_MASK))
                mask_q <= PWDATA[1:0];
        end
    end

    // ****************************************
    // trigger input
    // ****************************************
    // a pin pulse shorter than two clocks never passes the filter
    // the level resets low, so a pin idling low gives no false edge
    assign trig_lvl_d = (t2_q == t3_q) ? t3_q : trig_lvl_q;
    assign trig_edge  = mode_q[`TPW_B_TRIG_EDGE] ? (trig_lvl_d & ~trig_lvl_q)
                                                 : (~trig_lvl_d & trig_lvl_q);
    // pin edge only when the pin serves as trigger input
    assign trig_event = ctrl_q[`TPW_B_TRIG_OVF] ? OTHER_OVF
                      : (ctrl_q[`TPW_B_TRIG_PIN] & trig_edge);

    // three-stage trigger pin sampler
    // only the second and third stages are compared, never the first
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            t1_q       <= 1'b0;
            t2_q       <= 1'b0;
            t3_q       <= 1'b0;
            trig_lvl_q <= 1'b0;
        end else begin
            t1_q       <= TRIG_IN_PIN;
            t2_q       <= t1_q;
            t3_q       <= t2_q;
            trig_lvl_q <= trig_lvl_d;
        end
    end

    // ****************************************
    // start and stop
    // ****************************************
    assign pwm_mode = (mode_q[`TPW_F_OPSEL] == `TPW_OPSEL_PWM);
    // clearing start or leaving pwm operation ends the run next edge
    assign stop     = ~ctrl_q[`TPW_B_START] | ~pwm_mode;
    // start only from idle; running ignores triggers
    // a trigger while stopped or disabled is not remembered
    assign go = ~run_q & ~stop
              & (~mode_q[`TPW_B_TRIG_SRC] | trig_event);

    // ****************************************
    // modulator arithmetic
    // ****************************************
    // the first unit after a start follows the free divider phase, so the
    // first period may be up to one tick short; later periods are exact
    assign eight    = mode_q[`TPW_B_WIDTH8];
    assign width_n  = eight ? {8'h00, reload_q[15:8]} : reload_q;
    assign presc_m  = reload_q[7:0];
    assign period_n = eight ? `TPW_PERIOD8 : `TPW_PERIOD16;
    // one modulator unit: a tick, or m+1 ticks in 8-bit operation
    // in 16-bit operation every tick is a unit and the prescale is unused
    assign unit     = run_q & tick & (~eight | (pre_q == 8'h00));
    // a period restarts on the unit that finds the period count at one
    assign pstart   = go | (unit & (per_q == 16'h0001) & ~stop);

    // ****************************************
    // counter and pulse
    // ****************************************
    // run state, down counters and pulse level
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            run_q       <= 1'b0;
            out_q       <= 1'b0;
            cnt_q       <= `TPW_RST_TIMER;
            per_q       <= `TPW_RST_TIMER;
            pre_q       <= 8'h00;
            reload_q    <= `TPW_RST_TIMER;
            reload_ev_q <= 1'b0;
        end else begin
            reload_ev_q <= 1'b0;
            // a write in the very cycle of a start reaches the counter a period late
            if (wr_acc && hit(PADDR, `TPW_OFF_TIMER)) begin
                reload_q <= PWDATA[15:0];
                if (!run_q)
                    cnt_q <= PWDATA[15:0];
            end
            // a stop forces the pulse low, which the events logic counts as a fall
            if (run_q && stop) begin
                run_q <= 1'b0;
                out_q <= 1'b0;
            end else if (pstart) begin
                run_q       <= 1'b1;
                cnt_q       <= width_n;
                per_q       <= period_n;
                pre_q       <= presc_m;
                out_q       <= (width_n != 16'h0000);
                reload_ev_q <= 1'b1;
            end else if (run_q && tick) begin
                // the prescale spans m+1 ticks per unit and reloads at each wrap
                pre_q <= (pre_q == 8'h00) ? presc_m : pre_q - 8'h01;
                if (unit) begin
                    per_q <= dec16(per_q);
                    cnt_q <= dec16(cnt_q);
                    // drop the pulse on the unit that uses up the width
                    if (cnt_q <= 16'h0001)
                        out_q <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // events and interrupt
    // ****************************************
    assign fall_ev = out_prev_q & ~out_q;
    // low bit pulse fall, high bit period start
    assign ev_set  = {reload_ev_q, fall_ev};

    // sticky status, write one to clear, set wins
    // so an event in the clear cycle is never lost
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_prev_q <= 1'b0;
            ev_q       <= `TPW_RST_EV;
            IRQ        <= 1'b0;
        end else begin
            // previous pulse level for the fall detector
            out_prev_q <= out_q;
            if (wr_acc && hit(PADDR, `TPW_OFF_STATUS))
                ev_q <= (ev_q & ~PWDATA[1:0]) | ev_set;
            else
                ev_q <= ev_q | ev_set;
            // level request, one clock behind the status bits
            IRQ <= |(ev_q & mask_q);
        end
    end

    // ****************************************
    // output pin routing
    // ****************************************
    // pulse or port value onto the output pin
    // with the function select off the pin is a plain port bit
    always @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N)
            PULSE_OUT_PIN <= 1'b0;
        else if (ctrl_q[`TPW_B_OUT_FN])
            PULSE_OUT_PIN <= out_q;
        else
            PULSE_OUT_PIN <= ctrl_q[`TPW_B_PORT_OUT];
    end

endmodule // tpw_top
`default_nettype wire

// [hw/tpw_defines.vh]
// constants of the pwm timer channel: offsets, fields, reset values, counts
`ifndef TPW_DEFINES_VH
`define TPW_DEFINES_VH

// ****************************************
// register byte offsets
// ****************************************
`define TPW_OFF_MODE    8'h00
`define TPW_OFF_TIMER   8'h04
`define TPW_OFF_CTRL    8'h08
`define TPW_OFF_STATUS  8'h0c
`define TPW_OFF_MASK    8'h10

// ****************************************
// timer_mode_control fields
// ****************************************
`define TPW_F_OPSEL     1:0
`define TPW_OPSEL_PWM   2'h3
`define TPW_B_TRIG_EDGE 3
`define TPW_B_TRIG_SRC  4
`define TPW_B_WIDTH8    5
`define TPW_F_SRC       7:6
`define TPW_SRC_UNDIV   2'h0
`define TPW_SRC_DIV8    2'h1
`define TPW_SRC_DIV32   2'h2
`define TPW_SRC_SUB32   2'h3

// ****************************************
// control, status and mask fields
// ****************************************
`define TPW_B_START     0
`define TPW_B_TRIG_PIN  1
`define TPW_B_OUT_FN    2
`define TPW_B_TRIG_OVF  3
`define TPW_B_PORT_OUT  4
`define TPW_B_EV_FALL   0
`define TPW_B_EV_RELOAD 1
`define TPW_B_ST_RUN    4
`define TPW_B_ST_OUT    5
`define TPW_B_ST_TRIG   6

// ****************************************
// reset values
// ****************************************
`define TPW_RST_MODE    8'h00
`define TPW_RST_CTRL    8'h00
`define TPW_RST_TIMER   16'h0000
`define TPW_RST_EV      2'h0

// ****************************************
// timing counts
// ****************************************
`define TPW_PERIOD16    16'hffff
`define TPW_PERIOD8     16'h00ff
`define TPW_DIV8_LAST   3'h7
`define TPW_DIV32_LAST  5'h1f

`endif

// [hw/tpw_tick_gen.v]
// count source tick generator for the pwm timer channel
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defines.vh"

module tpw_tick_gen (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       sub_clk_pin,
    input  wire [1:0] src_sel,
    output reg        tick
);

    reg  [4:0] div_q;
    reg  [4:0] sub_div_q;
    reg        s1_q;
    reg        s2_q;
    reg        s3_q;
    reg        sub_lvl_q;
    wire       sub_lvl_d;
    wire       sub_rise;

    // ****************************************
    // sub-clock synchroniser and filter
    // ****************************************
    assign sub_lvl_d = (s2_q == s3_q) ? s3_q : sub_lvl_q; // counts once stages agree
    assign sub_rise  = sub_lvl_d & ~sub_lvl_q;

    // three-stage sampling of the low-speed clock pin
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q      <= 1'b0;
            s2_q      <= 1'b0;
            s3_q      <= 1'b0;
            sub_lvl_q <= 1'b0;
            sub_div_q <= 5'h00;
        end else begin
            s1_q      <= sub_clk_pin;
            s2_q      <= s1_q;
            s3_q      <= s2_q;
            sub_lvl_q <= sub_lvl_d;
            if (sub_rise)
                sub_div_q <= sub_div_q + 5'h01;
        end
    end

    // ****************************************
    // source selection
    // ****************************************
    // free-running divider and selected tick pulse
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 5'h00;
            tick  <= 1'b0;
        end else begin
            div_q <= div_q + 5'h01;
            case (src_sel)
                `TPW_SRC_UNDIV: tick <= 1'b1;
                `TPW_SRC_DIV8:  tick <= (div_q[2:0] == `TPW_DIV8_LAST);
                `TPW_SRC_DIV32: tick <= (div_q == `TPW_DIV32_LAST);
                default:        tick <= sub_rise && (sub_div_q == `TPW_DIV32_LAST);
            endcase
        end
    end

endmodule // tpw_tick_gen
`default_nettype wire

// [tb/tpw_top_properties.sv]
// port assertions of the pwm timer channel
`timescale 1ns/1ps
`default_nettype none
`include "tpw_defines.vh"
module tpw_top_properties (
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic        PREADY,
    input wire logic        PSLVERR,
    input wire logic        TRIG_IN_PIN,
    input wire logic        SUB_CLK_PIN,
    input wire logic        OTHER_OVF,
    input wire logic        PULSE_OUT_PIN,
    input wire logic        IRQ
);
    // ****************************************
    // shadow of written control registers
    // ****************************************
    logic [7:0] mode_q;
    logic [7:0] ctrl_q;
    logic [1:0] mask_q;
    logic       wr_ok;
    assign wr_ok = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
    // follow accepted writes only
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            mode_q <= 8'h00;
            ctrl_q <= 8'h00;
            mask_q <= 2'h0;
        end else if (wr_ok) begin
            if (PADDR == `TPW_OFF_MODE) mode_q <= PWDATA[7:0];
            if (PADDR == `TPW_OFF_CTRL) ctrl_q <= PWDATA[7:0];
            if (PADDR == `TPW_OFF_MASK) mask_q <= PWDATA[1:0];
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    a_ready_second_cycle: assert property (PSEL && PENABLE && !$past(PENABLE)
        |-> !PREADY ##1 PREADY) else $error("pready not in second access cycle");
    a_ready_one_cycle: assert property (PREADY |=> !PREADY)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("pslverr without pready");
    a_unmapped_err: assert property (PSEL && PENABLE && PREADY && PADDR > `TPW_OFF_MASK
        |-> PSLVERR) else $error("unmapped access not refused");
    a_timer_read_zero: assert property (PREADY && !PWRITE && PADDR == `TPW_OFF_TIMER
        |-> PRDATA == 32'h0) else $error("timer read not zero");
    a_port_out_follow: assert property (!ctrl_q[2]
        |=> PULSE_OUT_PIN == $past(ctrl_q[4])) else $error("pin not port output");
    a_stop_low: assert property (ctrl_q[2] && (!ctrl_q[0] || mode_q[1:0] != 2'h3)
        |-> ##2 !PULSE_OUT_PIN) else $error("pulse high while stopped");
    a_irq_on_fall: assert property ($fell(PULSE_OUT_PIN) && $past(ctrl_q[2])
        && ctrl_q[2] && mask_q[0] |-> ##[1:3] IRQ) else $error("no irq after fall");
    a_irq_masked: assert property ($past(mask_q) == 2'h0 |-> !IRQ)
        else $error("irq while masked");
endmodule // tpw_top_properties
bind tpw_top tpw_top_properties tpw_top_properties_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIG_IN_PIN(TRIG_IN_PIN),
    .SUB_CLK_PIN(SUB_CLK_PIN), .OTHER_OVF(OTHER_OVF), .PULSE_OUT_PIN(PULSE_OUT_PIN),
    .IRQ(IRQ));
`default_nettype wire

// [tb/tpw_partner.sv]
// far side model: trigger pin source and free low speed clock
`timescale 1ns/1ps
`default_nettype none
module tpw_partner (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic trig_req,
    output wire logic trig_pin,
    output var  logic sub_clk
);
    logic [2:0] hold_q;
    logic       phase_q;
    // sub clock rises every fourth cycle, each level two samples long as the
    // pin filter needs; trigger held high four cycles
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sub_clk <= 1'b0;
            phase_q <= 1'b0;
            hold_q  <= 3'h0;
        end else begin
            phase_q <= ~phase_q;
            if (phase_q) sub_clk <= ~sub_clk;
            if (trig_req) hold_q <= 3'h4;
            else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
        end
    end
    assign trig_pin = (hold_q != 3'h0);
endmodule // tpw_partner
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench of the pwm timer channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        REF_CLK;
    logic        RST_N;
    logic        PSEL;
    logic        PENABLE;
    logic        PWRITE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA;
    wire  [31:0] PRDATA;
    wire         PREADY;
    wire         PSLVERR;
    wire         TRIG_IN_PIN;
    wire         SUB_CLK_PIN;
    logic        OTHER_OVF;
    wire         PULSE_OUT_PIN;
    wire         IRQ;
    logic        trig_req;
    logic [31:0] rv;
    logic        ev;
    int          error_cnt;
    int          check_count;
    int          cyc = 0;
    tpw_top tpw_top_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .TRIG_IN_PIN(TRIG_IN_PIN), .SUB_CLK_PIN(SUB_CLK_PIN),
        .OTHER_OVF(OTHER_OVF), .PULSE_OUT_PIN(PULSE_OUT_PIN), .IRQ(IRQ));
    tpw_partner tpw_partner_i (.clk(REF_CLK), .rst_n(RST_N), .trig_req(trig_req),
        .trig_pin(TRIG_IN_PIN), .sub_clk(SUB_CLK_PIN));
    // ****************************************
    // clock, cycle stamp and helpers
    // ****************************************
    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end
    // cycle stamp for pulse timing
    always @(posedge REF_CLK) cyc <= cyc + 1;
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge REF_CLK);
        PSEL   <= 1'b1;
        PWRITE <= w;
        PADDR  <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        i = 0;
        do begin
            @(posedge REF_CLK);
            i++;
        end while (PREADY !== 1'b1 && i < 20);
        rv = PRDATA;
        ev = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        if (i >= 20) begin
            error_cnt++;
            tally_and_finish;
        end
    endtask
    // stamp of the cycle where the pulse pin reaches lv
    task automatic wait_lvl(input logic lv, output int t);
        int i;
        i = 0;
        while (PULSE_OUT_PIN !== lv && i < 70000) begin
            @(posedge REF_CLK);
            i++;
        end
        t = cyc;
        if (i >= 70000) begin
            error_cnt++;
            tally_and_finish;
        end
    endtask
    // one cycle trigger: pin request or other timer overflow
    task automatic kick(input logic pin);
        @(posedge REF_CLK);
        trig_req  <= pin;
        OTHER_OVF <= !pin;
        @(posedge REF_CLK);
        trig_req  <= 1'b0;
        OTHER_OVF <= 1'b0;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        logic [7:0] a[4] = '{8'h00, 8'h08, 8'h0c, 8'h10};
        foreach (a[k]) begin
            apb(a[k], 1'b0, 32'h0);
            chk("reset value", 32'h0, rv);
        end
        apb(8'h00, 1'b1, 32'he7);
        apb(8'h00, 1'b0, 32'h0);
        chk("mode rw", 32'he7, rv);
        apb(8'h04, 1'b1, 32'h1234);
        apb(8'h04, 1'b0, 32'h0);
        chk("timer read", 32'h0, rv);
        apb(8'h14, 1'b1, 32'h1);
        chk("err write", 32'h1, ev);
        apb(8'h14, 1'b0, 32'h0);
        chk("err read", 32'h1, ev);
        chk("err data", 32'h0, rv);
        apb(8'h10, 1'b1, 32'h1);
    endtask
    task automatic t_pwm16;
        int t0, t1, t2, t3;
        apb(8'h00, 1'b1, 32'h13);
        apb(8'h04, 1'b1, 32'h5);
        apb(8'h08, 1'b1, 32'h0d);
        repeat (10) @(posedge REF_CLK);
        chk("wait ovf", 32'h0, PULSE_OUT_PIN);
        kick(1'b0);
        wait_lvl(1'b1, t0);
        wait_lvl(1'b0, t1);
        chk("high16", 32'd5, t1 - t0);
        repeat (4) @(posedge REF_CLK);
        chk("irq", 32'h1, IRQ);
        apb(8'h0c, 1'b0, 32'h0);
        chk("status run", 32'h13, rv & 32'h33);
        apb(8'h0c, 1'b1, 32'h3);
        apb(8'h0c, 1'b0, 32'h0);
        chk("status clr", 32'h0, rv & 32'h3);
        chk("irq clr", 32'h0, IRQ);
        apb(8'h00, 1'b1, 32'h33);
        apb(8'h00, 1'b0, 32'h0);
        chk("width held", 32'h13, rv);
        apb(8'h04, 1'b1, 32'h3);
        kick(1'b0);
        wait_lvl(1'b1, t2);
        chk("period16", 32'd65535, t2 - t0);
        wait_lvl(1'b0, t3);
        chk("reload", 32'd3, t3 - t2);
        apb(8'h08, 1'b1, 32'h04);
        repeat (3) @(posedge REF_CLK);
        chk("stopped", 32'h0, PULSE_OUT_PIN);
        apb(8'h0c, 1'b0, 32'h0);
        chk("run off", 32'h0, rv & 32'h30);
    endtask
    task automatic t_pwm8;
        int t0, t1, t2;
        apb(8'h00, 1'b1, 32'h3b);
        apb(8'h04, 1'b1, 32'h0301);
        apb(8'h08, 1'b1, 32'h07);
        repeat (10) @(posedge REF_CLK);
        chk("wait pin", 32'h0, PULSE_OUT_PIN);
        kick(1'b1);
        wait_lvl(1'b1, t0);
        wait_lvl(1'b0, t1);
        chk("high8", 32'd6, t1 - t0);
        kick(1'b1);
        wait_lvl(1'b1, t2);
        chk("period8", 32'd510, t2 - t0);
        apb(8'h08, 1'b1, 32'h04);
    endtask
    task automatic t_src;
        int t0, t1, t2, t3;
        int dv[3] = '{8, 32, 128}; // sub clock rises every fourth cycle
        for (int s = 1; s < 4; s++) begin
            apb(8'h00, 1'b1, {24'h0, s[1:0], 6'h23});
            apb(8'h04, 1'b1, 32'h0200);
            apb(8'h08, 1'b1, 32'h05);
            wait_lvl(1'b1, t0);
            wait_lvl(1'b0, t1);
            wait_lvl(1'b1, t2);
            wait_lvl(1'b0, t3);
            chk("src high", 2 * dv[s-1], t3 - t2);
            // fall to fall: the first rise comes at the start, not on a divider tick
            chk("src period", 255 * dv[s-1], t3 - t1);
            apb(8'h08, 1'b1, 32'h04);
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        RST_N = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        OTHER_OVF = 1'b0;
        trig_req = 1'b0;
        error_cnt = 0;
        check_count = 0;
        repeat (12) @(posedge REF_CLK);
        RST_N <= 1'b1;
        t_regs;
        t_pwm16;
        t_pwm8;
        t_src;
        tally_and_finish;
    end
endmodule // testbench
`default_nettype wire
